// >>> hw/sfcd_top.sv
// command decoder and status register of a serial flash device
// assumes: array engine on i_clk runs erase and program jobs and answers
// with i_op_done; array and table data valid on i_rd_data for o_rd_addr
// within two clocks; serial clock at most i_clk/8
//
// Overview of operation
// - opcode 06h sets the write enable latch
// - opcode 04h clears the write enable latch
// - latch clears at reset, on 04h and when write jobs complete
// - program, erase and status write are refused while the latch is 0
// - 05h returns the status byte at any time except in power-down, repeated while clocked
// - status bit 0 is busy while a program, erase or status job runs
// - status bit 1 shows the write enable latch
// - bits 3:2 protect blocks; chip erase needs both zero
// - protect bits change only through status write 01h
// - disable bit 7 with write-protect low refuses status writes
// - 03h takes three address bytes, 0Bh one dummy more; data streams
// - 9Fh returns maker byte then two device bytes, no address
// - 5Ah takes address and dummy; ABh takes three ignored bytes
// - 90h takes two ignored bytes and a select; 00h maker first
// - 3Bh takes address and dummy, then streams two bits per clock
// - 20h is sector erase, 52h and D8h block erase, with address
// - 60h or C7h is chip erase with no address
// - 02h programs with address and data; B9h and ABh are opcode only
// - inputs sampled on rising, outputs shifted on falling serial edge
// - write and power commands need deselect on a byte boundary
// - status write takes only bits 7 and 3:2 of the written byte and sets bit 0 busy
`timescale 1ns/1ps
`default_nettype none

module sfcd_top (
   input wire logic i_clk, // system clock, 50 MHz
   input wire logic i_rstn, // synchronous reset, active low
   input wire logic i_cs_n, // chip select pin, active low
   input wire logic i_sclk, // serial clock pin
   input wire logic i_sio0, // data input pin level
   input wire logic i_wp_n, // write protect pin, active low
   input wire logic [7:0] i_rd_data, // array or table byte at o_rd_addr
   input wire logic i_op_done, // array job finished, one-cycle pulse
   output logic o_sio0, // data line 0 output value
   output logic o_sio0_oe, // data line 0 driven
   output logic o_sio1, // data line 1 output value
   output logic o_sio1_oe, // data line 1 driven
   output logic [23:0] o_rd_addr, // read address
   output logic o_rd_space, // 1 selects the parameter table
   output logic [7:0] o_pgm_data, // program data byte
   output logic o_pgm_valid, // program data strobe
   output sfcd_pkg::sfcd_op_t o_op, // job kind and address
   output logic o_op_start, // job start pulse
   output sfcd_pkg::sfcd_status_t o_status, // status register
   output logic o_power_down // deep power-down state
);
   import sfcd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection

   logic cs_s;
   logic sclk_s;
   logic si_s;
   logic wp_s;

   sfcd_sync #(
      .W(4),
      .RST_VAL(4'b1001)
   ) u_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_async({i_cs_n, i_sclk, i_sio0, i_wp_n}),
      .o_sync({cs_s, sclk_s, si_s, wp_s})
   );

   logic sclk_q;
   logic cs_q;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;

   assign sclk_rise = sclk_s & ~sclk_q;
   assign sclk_fall = ~sclk_s & sclk_q;
   assign cs_rise = cs_s & ~cs_q;

   ////////////////////////////////////////////////////////////////////////
   // status register

   logic status_write_disable;
   logic [1:0] bp;
   logic write_enable_latch;
   logic busy;
   logic pdown;
   sfcd_op_t op;
   logic op_start;
   sfcd_status_t status;

   always_comb begin
      status.status_write_disable = status_write_disable;
      status.zero = 3'h0;
      status.bp = bp;
      status.write_enable_latch = write_enable_latch;
      status.busy = busy;
   end

   ////////////////////////////////////////////////////////////////////////
   // frame state

   sfcd_phase_t phase;
   logic [2:0] in_bits;
   logic [2:0] byte_cnt;
   logic [6:0] rx;
   logic [7:0] opcode;
   logic [23:0] addr;
   logic [2:0] out_bits;
   logic [1:0] out_idx;
   logic [7:0] tx;
   logic so0;
   logic so1;
   logic [7:0] pgm_data;
   logic pgm_valid;

   sfcd_phase_t next_phase;
   logic [2:0] next_in_bits;
   logic [2:0] next_byte_cnt;
   logic [6:0] next_rx;
   logic [7:0] next_opcode;
   logic [23:0] next_addr;
   logic [2:0] next_out_bits;
   logic [1:0] next_out_idx;
   logic [7:0] next_tx;
   logic next_so0;
   logic next_so1;
   logic [7:0] next_pgm_data;
   logic next_pgm_valid;

   logic [7:0] byte_in;
   logic [7:0] src_byte;
   logic [7:0] word;
   logic dual;
   logic [2:0] step;
   logic accept;
   logic target_prot;

   assign byte_in = {rx, si_s};
   assign dual = (opcode == OP_DUAL_READ);
   assign step = dual ? STEP_DUAL : STEP_SINGLE;
   assign target_prot = sfcd_protected(bp, addr[BLK_MSB:BLK_LSB]);

   // busy lets only status reads through; power-down only the release
   always_comb begin
      if (pdown) begin
         accept = (byte_in == OP_POWER_RELEASE);
      end else if (busy) begin
         accept = (byte_in == OP_STATUS_READ);
      end else begin
         accept = sfcd_known(byte_in);
      end
   end

   // byte to shift out next
   always_comb begin
      src_byte = i_rd_data;
      unique case (opcode)
         OP_STATUS_READ: src_byte = status;
         OP_IDENT: begin
            unique case (out_idx)
               2'h0: src_byte = ID_MAKER;
               2'h1: src_byte = ID_TYPE;
               2'h2: src_byte = ID_DENSITY;
               default: src_byte = 8'h00;
            endcase
         end
         OP_SIG_READ: src_byte = ID_SIGNATURE;
         OP_MAKER_DEV: begin
            src_byte = (out_idx[0] ^ addr[0]) ? ID_SIGNATURE : ID_MAKER;
         end
         default: src_byte = i_rd_data;
      endcase
   end

   always_comb begin
      next_phase = phase;
      next_in_bits = in_bits;
      next_byte_cnt = byte_cnt;
      next_rx = rx;
      next_opcode = opcode;
      next_addr = addr;
      next_out_bits = out_bits;
      next_out_idx = out_idx;
      next_tx = tx;
      next_so0 = so0;
      next_so1 = so1;
      next_pgm_data = pgm_data;
      next_pgm_valid = 1'b0;
      word = tx;
      if (cs_s) begin
         next_phase = PH_IDLE;
         next_in_bits = 3'h0;
         next_byte_cnt = 3'h0;
      end else begin
         if (phase == PH_IDLE) begin
            next_phase = PH_IN;
         end
         if (sclk_rise) begin
            next_rx = byte_in[6:0];
            next_in_bits = 3'(in_bits + 3'h1);
            if (in_bits == LAST_BIT) begin
               if (byte_cnt != LEN_MAX) begin
                  next_byte_cnt = 3'(byte_cnt + 3'h1);
               end
               if (byte_cnt == 3'h0) begin
                  next_opcode = byte_in;
                  next_out_bits = 3'h0;
                  next_out_idx = 2'h0;
                  if (!accept) begin
                     next_phase = PH_IGNORE;
                  end else if (sfcd_data_start(byte_in) == LEN_OPCODE) begin
                     next_phase = PH_OUT;
                  end else begin
                     next_phase = PH_IN;
                  end
               end else if (phase != PH_IGNORE && phase != PH_OUT) begin
                  if (byte_cnt < LEN_ADDR) begin
                     next_addr = {addr[15:0], byte_in};
                  end
                  if (opcode == OP_PAGE_PGM && byte_cnt >= LEN_ADDR) begin
                     next_pgm_data = byte_in;
                     next_pgm_valid = write_enable_latch & ~target_prot;
                  end
                  if (sfcd_data_start(opcode) == 3'(byte_cnt + 3'h1)) begin
                     next_phase = PH_OUT;
                  end
               end
            end
         end
         if (sclk_fall && phase == PH_OUT) begin
            if (out_bits == 3'h0) begin
               word = src_byte;
               if (out_idx != 2'h3) begin
                  next_out_idx = 2'(out_idx + 2'h1);
               end
               if (opcode != OP_STATUS_READ && opcode != OP_IDENT &&
                   opcode != OP_SIG_READ && opcode != OP_MAKER_DEV) begin
                  next_addr = 24'(addr + 24'h00_0001); // wraps to zero
               end
            end
            next_so1 = word[7];
            if (dual) begin
               next_so0 = word[6];
               next_tx = {word[5:0], 2'b00};
            end else begin
               next_tx = {word[6:0], 1'b0};
            end
            next_out_bits = 3'(out_bits + step);
         end
      end
      if (!i_rstn) begin
         next_phase = PH_IDLE;
         next_in_bits = 3'h0;
         next_byte_cnt = 3'h0;
         next_rx = 7'h00;
         next_opcode = 8'h00;
         next_addr = 24'h00_0000;
         next_out_bits = 3'h0;
         next_out_idx = 2'h0;
         next_tx = 8'h00;
         next_so0 = 1'b0;
         next_so1 = 1'b0;
         next_pgm_data = 8'h00;
         next_pgm_valid = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      phase <= next_phase;
      in_bits <= next_in_bits;
      byte_cnt <= next_byte_cnt;
      rx <= next_rx;
      opcode <= next_opcode;
      addr <= next_addr;
      out_bits <= next_out_bits;
      out_idx <= next_out_idx;
      tx <= next_tx;
      so0 <= next_so0;
      so1 <= next_so1;
      pgm_data <= next_pgm_data;
      pgm_valid <= next_pgm_valid;
   end

   ////////////////////////////////////////////////////////////////////////
   // command completion at deselect

   logic next_status_write_disable;
   logic [1:0] next_bp;
   logic next_wel;
   logic next_busy;
   logic next_pdown;
   sfcd_op_t next_op;
   logic next_op_start;
   logic next_sclk_q;
   logic next_cs_q;
   logic commit;
   logic hw_locked;

   // only accepted frames ending on a byte boundary may commit
   assign commit = cs_rise && phase == PH_IN && in_bits == 3'h0;
   assign hw_locked = status_write_disable & ~wp_s;

   always_comb begin
      next_status_write_disable = status_write_disable;
      next_bp = bp;
      next_wel = write_enable_latch;
      next_busy = busy;
      next_pdown = pdown;
      next_op = op;
      next_op_start = 1'b0;
      next_sclk_q = sclk_s;
      next_cs_q = cs_s;
      if (i_op_done && busy) begin
         next_busy = 1'b0;
         next_wel = 1'b0;
      end
      if (commit) begin
         unique case (opcode)
            OP_LATCH_SET: begin
               if (byte_cnt == LEN_OPCODE) begin
                  next_wel = 1'b1;
               end
            end
            OP_LATCH_CLEAR: begin
               if (byte_cnt == LEN_OPCODE) begin
                  next_wel = 1'b0;
               end
            end
            OP_STATUS_WRITE: begin
               if (byte_cnt == LEN_STATUS_WRITE && write_enable_latch && !hw_locked) begin
                  next_status_write_disable = addr[WR_STATUS_WRITE_DISABLE_POS];
                  next_bp = addr[WR_BP_MSB:WR_BP_LSB];
                  next_busy = 1'b1;
                  next_op = '{kind: OPK_STATUS, addr: addr};
                  next_op_start = 1'b1;
               end
            end
            OP_ERASE_SECTOR, OP_ERASE_BLOCK_A, OP_ERASE_BLOCK_B: begin
               if (byte_cnt == LEN_ADDR && write_enable_latch && !target_prot) begin
                  next_busy = 1'b1;
                  next_op.kind = (opcode == OP_ERASE_SECTOR) ?
                                 OPK_SECTOR : OPK_BLOCK;
                  next_op.addr = addr;
                  next_op_start = 1'b1;
               end
            end
            OP_ERASE_CHIP_A, OP_ERASE_CHIP_B: begin
               if (byte_cnt == LEN_OPCODE && write_enable_latch && bp == 2'h0) begin
                  next_busy = 1'b1;
                  next_op = '{kind: OPK_CHIP, addr: 24'h00_0000};
                  next_op_start = 1'b1;
               end
            end
            OP_PAGE_PGM: begin
               if (byte_cnt >= LEN_PGM_MIN && write_enable_latch && !target_prot) begin
                  next_busy = 1'b1;
                  next_op = '{kind: OPK_PAGE, addr: addr};
                  next_op_start = 1'b1;
               end
            end
            OP_POWER_DOWN: begin
               if (byte_cnt == LEN_OPCODE) begin
                  next_pdown = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // release: any ABh frame not ignored that ends on a byte boundary
      if (cs_rise && phase != PH_IGNORE && opcode == OP_POWER_RELEASE &&
          byte_cnt != 3'h0 && in_bits == 3'h0) begin
         next_pdown = 1'b0;
      end
      if (!i_rstn) begin
         next_status_write_disable = STATUS_WRITE_DISABLE_RESET;
         next_bp = BP_RESET;
         next_wel = 1'b0;
         next_busy = 1'b0;
         next_pdown = 1'b0;
         next_op = '{kind: OPK_NONE, addr: 24'h00_0000};
         next_op_start = 1'b0;
         next_sclk_q = 1'b0;
         next_cs_q = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      status_write_disable <= next_status_write_disable;
      bp <= next_bp;
      write_enable_latch <= next_wel;
      busy <= next_busy;
      pdown <= next_pdown;
      op <= next_op;
      op_start <= next_op_start;
      sclk_q <= next_sclk_q;
      cs_q <= next_cs_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign o_sio1 = so1;
   assign o_sio0 = so0;
   assign o_sio1_oe = (phase == PH_OUT) & ~cs_s;
   assign o_sio0_oe = (phase == PH_OUT) & ~cs_s & dual;
   assign o_rd_addr = addr;
   assign o_rd_space = (opcode == OP_PARAM_READ);
   assign o_pgm_data = pgm_data;
   assign o_pgm_valid = pgm_valid;
   assign o_op = op;
   assign o_op_start = op_start;
   assign o_status = status;
   assign o_power_down = pdown;

endmodule : sfcd_top

`default_nettype wire

// >>> hw/sfcd_pkg.sv
// shared constants, types and helpers of the serial flash command decoder
// assumes: 24-bit addressing, 2 address bits above bit 15 pick one of 4 blocks
package sfcd_pkg;

   // opcodes
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_IDENT = 8'h9F;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_PARAM_READ = 8'h5A;
   localparam logic [7:0] OP_SIG_READ = 8'hAB;
   localparam logic [7:0] OP_MAKER_DEV = 8'h90;
   localparam logic [7:0] OP_DUAL_READ = 8'h3B;
   localparam logic [7:0] OP_ERASE_SECTOR = 8'h20;
   localparam logic [7:0] OP_ERASE_BLOCK_A = 8'h52;
   localparam logic [7:0] OP_ERASE_BLOCK_B = 8'hD8;
   localparam logic [7:0] OP_ERASE_CHIP_A = 8'h60;
   localparam logic [7:0] OP_ERASE_CHIP_B = 8'hC7;
   localparam logic [7:0] OP_PAGE_PGM = 8'h02;
   localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
   localparam logic [7:0] OP_POWER_RELEASE = 8'hAB;

   // frame lengths in bytes, opcode included, and last bit index of a byte
   localparam logic [2:0] LEN_OPCODE = 3'h1;
   localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
   localparam logic [2:0] LEN_ADDR = 3'h4;
   localparam logic [2:0] LEN_DUMMY = 3'h5;
   localparam logic [2:0] LEN_PGM_MIN = 3'h5;
   localparam logic [2:0] LEN_MAX = 3'h7;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // bit-shift steps per falling edge
   localparam logic [2:0] STEP_SINGLE = 3'h1;
   localparam logic [2:0] STEP_DUAL = 3'h2;

   // block select field of the address
   localparam int BLK_MSB = 17;
   localparam int BLK_LSB = 16;
   localparam logic [2:0] BLK_COUNT = 3'h4;

   // status field positions inside the written byte
   localparam int WR_STATUS_WRITE_DISABLE_POS = 7;
   localparam int WR_BP_MSB = 3;
   localparam int WR_BP_LSB = 2;

   // reset values
   localparam logic [1:0] BP_RESET = 2'h3;
   localparam logic STATUS_WRITE_DISABLE_RESET = 1'b0;

   // identity bytes: values are arbitrary
   localparam logic [7:0] ID_MAKER = 8'h5C;
   localparam logic [7:0] ID_TYPE = 8'h21;
   localparam logic [7:0] ID_DENSITY = 8'h12;
   localparam logic [7:0] ID_SIGNATURE = 8'h11;

   typedef struct packed {
      logic status_write_disable;
      logic [2:0] zero;
      logic [1:0] bp;
      logic write_enable_latch;
      logic busy;
   } sfcd_status_t;

   typedef enum logic [2:0] {
      OPK_NONE = 3'h0,
      OPK_STATUS = 3'h1,
      OPK_SECTOR = 3'h2,
      OPK_BLOCK = 3'h3,
      OPK_CHIP = 3'h4,
      OPK_PAGE = 3'h5
   } sfcd_op_kind_t;

   typedef struct packed {
      sfcd_op_kind_t kind;
      logic [23:0] addr;
   } sfcd_op_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_IN = 2'h1,
      PH_OUT = 2'h3,
      PH_IGNORE = 2'h2
   } sfcd_phase_t;

   // byte index at which output starts, 0 for no output
   function automatic logic [2:0] sfcd_data_start(input logic [7:0] op);
      logic [2:0] r;
      r = 3'h0;
      unique case (op)
         OP_STATUS_READ, OP_IDENT: r = LEN_OPCODE;
         OP_READ, OP_SIG_READ, OP_MAKER_DEV: r = LEN_ADDR;
         OP_FAST_READ, OP_PARAM_READ, OP_DUAL_READ: r = LEN_DUMMY;
         default: r = 3'h0;
      endcase
      return r;
   endfunction : sfcd_data_start

   function automatic logic sfcd_known(input logic [7:0] op);
      logic r;
      r = 1'b0;
      unique case (op)
         OP_LATCH_SET, OP_LATCH_CLEAR, OP_STATUS_WRITE, OP_STATUS_READ,
         OP_IDENT, OP_READ, OP_FAST_READ, OP_PARAM_READ, OP_SIG_READ,
         OP_MAKER_DEV, OP_DUAL_READ, OP_ERASE_SECTOR, OP_ERASE_BLOCK_A,
         OP_ERASE_BLOCK_B, OP_ERASE_CHIP_A, OP_ERASE_CHIP_B, OP_PAGE_PGM,
         OP_POWER_DOWN: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : sfcd_known

   // level 1 covers block 3, level 2 blocks 2-3, level 3 all
   function automatic logic sfcd_protected(input logic [1:0] bp,
                                           input logic [1:0] blk);
      return (bp == 2'h3) ||
             ((bp != 2'h0) && ({1'b0, blk} >= (BLK_COUNT - {1'b0, bp})));
   endfunction : sfcd_protected

endpackage : sfcd_pkg

// >>> hw/sfcd_sync.sv
// two-flop synchroniser for a group of asynchronous inputs
// assumes: bits are independent levels; reset value given per bit
`timescale 1ns/1ps
`default_nettype none

module sfcd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_clk, // system clock
   input wire logic i_rstn, // synchronous reset, active low
   input wire logic [W-1:0] i_async, // inputs from another domain
   output logic [W-1:0] o_sync // synchronised levels
);

   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;

   always_comb begin
      next_meta = i_async;
      next_sync = meta;
      if (!i_rstn) begin
         next_meta = RST_VAL;
         next_sync = RST_VAL;
      end
   end

   always_ff @(posedge i_clk) begin
      meta <= next_meta;
      o_sync <= next_sync;
   end

endmodule : sfcd_sync

`default_nettype wire

// >>> tb/sfcd_top_props.sv
// checker of the command decoder's status, job and output-enable ports
// assumes: bound into sfcd_top, one clock domain on i_clk
`timescale 1ns/1ps
`default_nettype none

module sfcd_top_props
   import sfcd_pkg::*;
(
   input wire logic i_clk, // system clock
   input wire logic i_rstn, // synchronous reset, active low
   input wire logic i_cs_n, // chip select pin
   input wire logic i_op_done, // job finished pulse
   input wire logic o_sio0_oe, // line 0 driven
   input wire logic o_sio1_oe, // line 1 driven
   input wire logic o_pgm_valid, // program byte strobe
   input wire sfcd_pkg::sfcd_op_t o_op, // job kind and address
   input wire logic o_op_start, // job start pulse
   input wire sfcd_pkg::sfcd_status_t o_status, // status register
   input wire logic o_power_down // deep power-down state
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   chk_start_busy:
      assert property (o_op_start |-> o_status.busy)
      else $error("job start without busy");
   chk_busy_hold:
      assert property (o_status.busy && !i_op_done |=> o_status.busy)
      else $error("busy dropped without done");
   chk_done_clears:
      assert property (o_status.busy && i_op_done
                       |=> !o_status.busy && !o_status.write_enable_latch)
      else $error("done left busy or latch set");
   chk_start_wel:
      assert property (o_op_start |-> o_status.write_enable_latch)
      else $error("job started with latch clear");
   chk_pgm_wel:
      assert property (o_pgm_valid |-> o_status.write_enable_latch)
      else $error("program byte with latch clear");
   chk_zero_bits:
      assert property (o_status.zero == 3'h0)
      else $error("status bits 6 to 4 not zero");
   chk_chip_bp:
      assert property (o_op_start && o_op.kind == OPK_CHIP
                       |-> o_status.bp == 2'h0)
      else $error("chip erase under protection");
   chk_bp_write:
      assert property ($changed(o_status.bp) |->
         (o_op_start || $past(o_op_start)) && o_op.kind == OPK_STATUS)
      else $error("protect bits changed outside status write");
   chk_idle_oe:
      assert property (i_cs_n [*5] |-> !o_sio1_oe && !o_sio0_oe)
      else $error("output driven while deselected");
   chk_dual_oe:
      assert property (o_sio0_oe |-> o_sio1_oe)
      else $error("line 0 driven alone");
   chk_pd_quiet:
      assert property (o_power_down |-> !o_op_start)
      else $error("job started in power-down");

   cov_job: cover property (o_op_start);
   cov_done: cover property (o_status.busy && i_op_done);
   cov_dual: cover property (o_sio0_oe);
endmodule : sfcd_top_props

bind sfcd_top sfcd_top_props i_props (.i_clk, .i_rstn, .i_cs_n,
   .i_op_done, .o_sio0_oe, .o_sio1_oe, .o_pgm_valid, .o_op, .o_op_start,
   .o_status, .o_power_down);

`default_nettype wire

// >>> tb/sfcd_host.sv
// serial host model: mode 0 frames, 160 ns serial clock
// assumes: i_clk is 50 MHz; caller waits for a frame to end
`timescale 1ns/1ps
`default_nettype none

module sfcd_host (
   input wire logic i_clk, // system clock
   input wire logic i_so, // device serial output line
   input wire logic i_so0, // device line 0 output, dual read
   output logic o_cs_n, // chip select, active low
   output logic o_sclk, // serial clock, idle low
   output logic o_si // serial data to device
);
   logic [31:0] rx0; // line 0 bits of the last frame

   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_si = 1'b0;
   end

   // ntx bytes from the top of tx, then nrx bytes read into rx
   task automatic frame(input logic [55:0] tx, input int ntx,
                        input int nrx, output logic [31:0] rx);
      rx = '0;
      rx0 = '0;
      @(posedge i_clk) o_cs_n <= 1'b0;
      for (int i = 0; i < 8 * (ntx + nrx); i++) begin
         @(posedge i_clk);
         o_sclk <= 1'b0;
         o_si <= (i < 8 * ntx) ? tx[55 - i] : ~o_si;
         repeat (4) @(posedge i_clk);
         o_sclk <= 1'b1;
         repeat (2) @(posedge i_clk);
         if (i >= 8 * ntx) begin
            rx = {rx[30:0], i_so};
            rx0 = {rx0[30:0], i_so0};
         end
         @(posedge i_clk);
      end
      @(posedge i_clk) o_sclk <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_cs_n <= 1'b1;
      o_si <= ~o_si;
      repeat (8) @(posedge i_clk);
   endtask : frame
endmodule : sfcd_host

`default_nettype wire

// >>> tb/test_sfcd_top.sv
// testbench of the command decoder: host frames and a simple array engine
// assumes: sfcd_host drives the serial pins; read data = addr xor a5h
`timescale 1ns/1ps
`default_nettype none

module test_sfcd_top;
   import sfcd_pkg::*;
   logic clk, rstn, wp_n, op_done, cs_n, sclk, si;
   logic sio0, sio0_oe, sio1, sio1_oe, rd_space, pgm_valid, op_start, pdn;
   logic [7:0] rd_data, pgm_data, last_pgm;
   logic [23:0] rd_addr;
   logic [31:0] rx;
   sfcd_op_t op;
   sfcd_status_t st;
   int err_count = 0;
   int compares = 0;
   int starts = 0;
   logic [7:0] ops [6] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h02};
   int lens [6] = '{4, 4, 4, 1, 1, 5};
   sfcd_op_kind_t kinds [6] = '{OPK_SECTOR, OPK_BLOCK, OPK_BLOCK,
                                OPK_CHIP, OPK_CHIP, OPK_PAGE};

   sfcd_top i_dut (.i_clk(clk), .i_rstn(rstn), .i_cs_n(cs_n),
      .i_sclk(sclk), .i_sio0(sio0_oe ? sio0 : si), .i_wp_n(wp_n),
      .i_rd_data(rd_data), .i_op_done(op_done), .o_sio0(sio0),
      .o_sio0_oe(sio0_oe), .o_sio1(sio1), .o_sio1_oe(sio1_oe),
      .o_rd_addr(rd_addr), .o_rd_space(rd_space), .o_pgm_data(pgm_data),
      .o_pgm_valid(pgm_valid), .o_op(op), .o_op_start(op_start),
      .o_status(st), .o_power_down(pdn));
   sfcd_host i_host (.i_clk(clk), .i_so(sio1), .i_so0(sio0),
      .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      rd_data <= rd_addr[7:0] ^ 8'hA5;
      if (op_start === 1'b1) starts++;
      if (pgm_valid === 1'b1) last_pgm <= pgm_data;
   end

   task check(input string nm, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task send(input logic [7:0] b, input logic [47:0] rest, input int n);
      i_host.frame({b, rest}, n, 0, rx);
   endtask : send

   task rd(input logic [7:0] e);
      i_host.frame({8'h05, 48'h0}, 1, 2, rx);
      check("status read", rx[15:0], {e, e});
   endtask : rd

   task finish_job;
      repeat (20) @(posedge clk);
      op_done <= 1'b1;
      @(posedge clk) op_done <= 1'b0;
      @(posedge clk);
   endtask : finish_job

   task give_verdict;
      if (err_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   initial begin
      #1ms;
      err_count++;
      give_verdict();
   end

   initial begin
      rstn = 1'b0;
      wp_n = 1'b1;
      op_done = 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      check("reset status", st, 8'h0C);
      rd(8'h0C);
      send(8'h06, 48'h0, 1);
      rd(8'h0E);
      send(8'h04, 48'h0, 1);
      rd(8'h0C);
      send(8'h06, 48'h0, 1);
      send(8'h02, {24'h00_0010, 8'hAA, 16'h0}, 5);
      check("protected job", starts, 0);
      send(8'h06, 48'h0, 1);
      send(8'h01, {8'hF3, 40'h0}, 2);
      check("status job", starts, 1);
      rd(8'h83);
      finish_job();
      rd(8'h80);
      // latch clear, nothing protected: only the latch can refuse this
      send(8'h20, {24'h01_2345, 24'h0}, 4);
      check("refused job", starts, 1);
      wp_n <= 1'b0;
      send(8'h06, 48'h0, 1);
      send(8'h01, {8'h0C, 40'h0}, 2);
      check("locked bits", st[7:2], 6'h20);
      wp_n <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         send(8'h06, 48'h0, 1);
         send(ops[k], {24'h012345, 8'hAA, 16'h0}, lens[k]);
         check("job kind", op.kind, kinds[k]);
         check("busy", st.busy, 1'b1);
         if (kinds[k] != OPK_CHIP) check("addr", op.addr, 24'h012345);
         finish_job();
      end
      check("program byte", last_pgm, 8'hAA);
      i_host.frame({8'h9F, 48'h0}, 1, 3, rx);
      check("ident", rx[23:0], 24'h5C2112);
      i_host.frame({8'h90, 24'h000001, 24'h0}, 4, 2, rx);
      check("device first", rx[15:0], 16'h115C);
      i_host.frame({8'h90, 24'h000000, 24'h0}, 4, 2, rx);
      check("maker first", rx[15:0], 16'h5C11);
      i_host.frame({8'h03, 24'h0001FE, 24'h0}, 4, 3, rx);
      check("read", rx[23:0], 24'h5B5AA5);
      i_host.frame({8'h0B, 24'h0001FE, 24'h0}, 5, 3, rx);
      check("fast read", rx[23:0], 24'h5B5AA5);
      i_host.frame({8'h3B, 24'h0001FE, 24'h0}, 5, 1, rx);
      // bytes 5bh then 5ah: odd bits on line 1, even bits on line 0
      check("dual line 1", rx[7:0], 8'h33);
      check("dual line 0", i_host.rx0[7:0], 8'hDC);
      send(8'hB9, 48'h0, 1);
      check("power down", pdn, 1'b1);
      send(8'h06, 48'h0, 1);
      check("asleep latch", st.write_enable_latch, 1'b0);
      send(8'hAB, 48'h0, 1);
      check("released", pdn, 1'b0);
      i_host.frame({8'hAB, 48'h0}, 4, 1, rx);
      check("signature", rx[7:0], 8'h11);
      i_host.frame({8'h5A, 24'h00_01FE, 24'h0}, 5, 1, rx);
      check("table data", rx[7:0], 8'h5B);
      check("table space", rd_space, 1'b1);
      give_verdict();
   end
endmodule : test_sfcd_top

`default_nettype wire
